//--- logic/program_flash_self_write.v
`include "flash_self_write_defs.vh"

// Behaviour
// - table read copies one byte into latch
// - pointer bit 0 picks high or low byte
// - table read may update pointer automatically
// - four pointer modes, low 21 bits only
// - erase unit is 64-byte row only
// - erase row chosen by pointer bits 21..6
// - start only after 55h then AAh unlock
// - start with erase selected erases, stalls ~2ms
// - core halted during long cycle; timer ends it
// - program unit is 8-byte block only
// - eight holding bytes, table write fills one
// - write byte by bits 2..0; block by 21..3
// - control write launches program cycle after filling
// - program start stalls core ~2ms writing block
// - hardware clears start, ignores clear, sets done
// - erase select cleared when erase completes
module program_flash_self_write #(
	parameter LONG_CYCLES = `FSW_LONG_CYCLES,
	parameter CNT_W = 17
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// flash array read port
	output reg [20:0] flash_addr,
	input wire [15:0] flash_rdata,
	// flash array long operation
	output reg flash_erase,
	output reg flash_prog,
	output reg [21:0] flash_op_addr,
	output reg [63:0] flash_wdata,
	// core halt
	output reg core_stall
);

	// main states, one-hot
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_LONG = 3'b100;
	// unlock progress, one-hot
	localparam U_IDLE = 3'b001;
	localparam U_HALF = 3'b010;
	localparam U_ARM = 3'b100;

	// state registers
	reg [2:0] st_ff;
	reg [2:0] unlock_ff;

	// table pointer and latch
	reg [21:0] ptr_ff;
	reg [7:0] latch_ff;

	// flash_control bits
	reg pgm_sel_ff;
	reg cfg_sel_ff;
	reg erase_sel_ff;
	reg write_enable_bit_ff;
	reg start_ff;

	// status flag and table read byte select
	reg done_flag_ff;
	reg byte_hi_ff;

	// long cycle launch and holding bytes
	reg timer_start_ff;
	reg [7:0] hold_ff [0:7];
	wire timer_done;
	integer i;

	// step the low 21 pointer bits, bit 21 untouched
	function [21:0] ptr_after;
		input [21:0] p;
		input [1:0] mode;
		begin
			if (mode == `FSW_MODE_POSTINC || mode == `FSW_MODE_PREINC)
				ptr_after = {p[21], p[20:0] + 21'h000001};
			else if (mode == `FSW_MODE_POSTDEC)
				ptr_after = {p[21], p[20:0] - 21'h000001};
			else
				ptr_after = p;
		end
	endfunction

	// byte-lane merge of a write into an old word
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer k;
		begin
			lane_merge = old;
			for (k = 0; k < 4; k = k + 1)
				if (sel[k])
					lane_merge[k*8 +: 8] = nw[k*8 +: 8];
		end
	endfunction

	// request decode
	wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_o & st_ff[0];
	wire wr = acc & wb_we_i;
	wire lane0 = wb_sel_i[0];
	// pointer step and lane merge
	wire [1:0] op_mode = wb_dat_i[`FSW_OP_MODE_LSB +: 2];
	wire [21:0] op_next = ptr_after(ptr_ff, op_mode);
	wire [21:0] op_eff = (op_mode == `FSW_MODE_PREINC) ? op_next : ptr_ff;
	wire [31:0] ptr_merged = lane_merge({10'h000, ptr_ff}, wb_dat_i, wb_sel_i);
	// launch check and control readback
	wire start_ok = wb_dat_i[`FSW_CTL_START_BIT] & (unlock_ff == U_ARM) &
		wb_dat_i[`FSW_CTL_WRITE_ENABLE_BIT_BIT] & wb_dat_i[`FSW_CTL_PGM_BIT] & ~wb_dat_i[`FSW_CTL_CFG_BIT];
	wire [7:0] ctl_rd = {pgm_sel_ff, cfg_sel_ff, 1'b0, erase_sel_ff, 1'b0, write_enable_bit_ff, start_ff, 1'b0};

	// long cycle timer
	prog_timer #(
		.COUNT(LONG_CYCLES),
		.CNT_W(CNT_W)
	) u_prog_timer (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.start(timer_start_ff),
		.done_ff(timer_done)
	);

	// bus slave, table operations, unlock and long cycle control
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// state and table registers
			st_ff <= ST_IDLE;
			unlock_ff <= U_IDLE;
			ptr_ff <= `FSW_RST_PTR;
			latch_ff <= `FSW_RST_BYTE;
			// control and status bits
			pgm_sel_ff <= 1'b0;
			cfg_sel_ff <= 1'b0;
			erase_sel_ff <= 1'b0;
			write_enable_bit_ff <= 1'b0;
			start_ff <= 1'b0;
			done_flag_ff <= 1'b0;
			byte_hi_ff <= 1'b0;
			timer_start_ff <= 1'b0;
			// bus outputs
			wb_dat_o <= 32'h00000000;
			wb_ack_o <= 1'b0;
			// flash side outputs
			flash_addr <= 21'h000000;
			flash_erase <= 1'b0;
			flash_prog <= 1'b0;
			flash_op_addr <= `FSW_RST_PTR;
			flash_wdata <= 64'h0000000000000000;
			core_stall <= 1'b0;
			// holding bytes cleared
			for (i = 0; i < 8; i = i + 1)
				hold_ff[i] <= `FSW_RST_BYTE;
		end
		else
		begin
			// one-cycle strobes default low
			wb_ack_o <= 1'b0;
			timer_start_ff <= 1'b0;
			case (st_ff)
				ST_IDLE:
				begin
					if (acc)
					begin
						// any access other than the next key breaks the sequence
						unlock_ff <= U_IDLE;
						wb_ack_o <= 1'b1;
						wb_dat_o <= 32'h00000000;
						// table_pointer, byte lanes merged
						if (wb_adr_i == `FSW_ADR_PTR)
						begin
							wb_dat_o <= {10'h000, ptr_ff};
							if (wr)
								ptr_ff <= ptr_merged[21:0];
						end
						// table_latch
						else if (wb_adr_i == `FSW_ADR_LATCH)
						begin
							wb_dat_o <= {24'h000000, latch_ff};
							if (wr && lane0)
								latch_ff <= wb_dat_i[7:0];
						end
						// flash_control
						else if (wb_adr_i == `FSW_ADR_CTL)
						begin
							wb_dat_o <= {24'h000000, ctl_rd};
							if (wr && lane0)
							begin
								pgm_sel_ff <= wb_dat_i[`FSW_CTL_PGM_BIT];
								cfg_sel_ff <= wb_dat_i[`FSW_CTL_CFG_BIT];
								erase_sel_ff <= wb_dat_i[`FSW_CTL_ERASE_BIT];
								write_enable_bit_ff <= wb_dat_i[`FSW_CTL_WRITE_ENABLE_BIT_BIT];
								// start only right after the armed unlock and with writes enabled
								if (start_ok)
								begin
									start_ff <= 1'b1;
									st_ff <= ST_LONG;
									core_stall <= 1'b1;
									timer_start_ff <= 1'b1;
									// kind of cycle follows the erase bit of this write
									if (wb_dat_i[`FSW_CTL_ERASE_BIT])
									begin
										flash_erase <= 1'b1;
										flash_op_addr <= {ptr_ff[21:6], 6'h00};
									end
									else
									begin
										flash_prog <= 1'b1;
										flash_op_addr <= {ptr_ff[21:3], 3'h0};
									end
									// holding bytes handed over at launch
									for (i = 0; i < 8; i = i + 1)
										flash_wdata[i*8 +: 8] <= hold_ff[i];
								end
							end
						end
						else if (wb_adr_i == `FSW_ADR_UNLOCK)
						begin
							// unlock port reads as zero
							if (wr && lane0 && wb_dat_i[7:0] == `FSW_UNLOCK_KEY1)
								unlock_ff <= U_HALF;
							else if (wr && lane0 && wb_dat_i[7:0] == `FSW_UNLOCK_KEY2 && unlock_ff == U_HALF)
								unlock_ff <= U_ARM;
						end
						// table operation, reads as zero
						else if (wb_adr_i == `FSW_ADR_OP)
						begin
							if (wr && lane0 && wb_dat_i[`FSW_OP_RD_BIT])
							begin
								// fetch the word, answer once the byte is latched
								wb_ack_o <= 1'b0;
								flash_addr <= op_eff[21:1];
								byte_hi_ff <= op_eff[0];
								ptr_ff <= op_next;
								st_ff <= ST_READ;
							end
							else if (wr && lane0 && wb_dat_i[`FSW_OP_WR_BIT])
							begin
								// short write into one holding byte
								hold_ff[op_eff[2:0]] <= latch_ff;
								ptr_ff <= op_next;
							end
						end
						// status, done flag write-one-to-clear
						else if (wb_adr_i == `FSW_ADR_STS)
						begin
							wb_dat_o <= {30'h00000000, ~st_ff[0], done_flag_ff};
							if (wr && lane0 && wb_dat_i[`FSW_STS_DONE_BIT])
								done_flag_ff <= 1'b0;
						end
					end
				end
				ST_READ:
				begin
					// odd address returns the high byte of the word
					latch_ff <= byte_hi_ff ? flash_rdata[15:8] : flash_rdata[7:0];
					wb_dat_o <= 32'h00000000;
					wb_ack_o <= 1'b1;
					st_ff <= ST_IDLE;
				end
				ST_LONG:
				begin
					// bus held off; holding bytes untouched until the timer ends
					if (timer_done)
					begin
						st_ff <= ST_IDLE;
						core_stall <= 1'b0;
						start_ff <= 1'b0;
						flash_erase <= 1'b0;
						flash_prog <= 1'b0;
						// erase select drops only after an erase
						if (flash_erase)
							erase_sel_ff <= 1'b0;
					end
				end
				// unused codes fall back to idle
				default:
				begin
					st_ff <= ST_IDLE;
				end
			endcase
			// completion sets the flag, winning over a clear
			if (timer_done)
				done_flag_ff <= 1'b1;
		end
	end

endmodule // program_flash_self_write

//--- logic/flash_self_write_defs.vh
`ifndef FLASH_SELF_WRITE_DEFS_VH
`define FLASH_SELF_WRITE_DEFS_VH

// register byte offsets on the bus
`define FSW_ADR_PTR 8'h00
`define FSW_ADR_LATCH 8'h04
`define FSW_ADR_CTL 8'h08
`define FSW_ADR_UNLOCK 8'h0C
`define FSW_ADR_OP 8'h10
`define FSW_ADR_STS 8'h14

// flash_control field positions
`define FSW_CTL_PGM_BIT 7
`define FSW_CTL_CFG_BIT 6
`define FSW_CTL_ERASE_BIT 4
`define FSW_CTL_WRERR_BIT 3
`define FSW_CTL_WRITE_ENABLE_BIT_BIT 2
`define FSW_CTL_START_BIT 1

// table operation register fields
`define FSW_OP_RD_BIT 0
`define FSW_OP_WR_BIT 1
`define FSW_OP_MODE_LSB 2
`define FSW_MODE_KEEP 2'h0
`define FSW_MODE_POSTINC 2'h1
`define FSW_MODE_POSTDEC 2'h2
`define FSW_MODE_PREINC 2'h3

// status register fields
`define FSW_STS_DONE_BIT 0
`define FSW_STS_BUSY_BIT 1

// unlock keys
`define FSW_UNLOCK_KEY1 8'h55
`define FSW_UNLOCK_KEY2 8'hAA

// reset values
`define FSW_RST_PTR 22'h000000
`define FSW_RST_BYTE 8'h00

// long cycle timing
`define FSW_PROG_TIME_US 2000
`define FSW_CLK_MHZ 25
`define FSW_LONG_CYCLES (`FSW_PROG_TIME_US * `FSW_CLK_MHZ)

`endif

//--- logic/prog_timer.v
// self-timed long cycle: done pulses COUNT cycles after start
module prog_timer #(
	parameter COUNT = 50000,
	parameter CNT_W = 17
) (
	// clock and reset
	input wire core_clk,
	input wire rst_n,
	// control
	input wire start,
	output reg done_ff
);

	localparam [CNT_W-1:0] LOAD = COUNT;
	localparam [CNT_W-1:0] ONE = 1;

	reg [CNT_W-1:0] cnt_ff;
	reg run_ff;

	// down counter, one-cycle done at expiry
	always @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_ff <= {CNT_W{1'b0}};
			run_ff <= 1'b0;
			done_ff <= 1'b0;
		end
		else
		begin
			done_ff <= 1'b0;
			if (start)
			begin
				cnt_ff <= LOAD;
				run_ff <= 1'b1;
			end
			else if (run_ff)
			begin
				if (cnt_ff <= ONE + ONE)
				begin
					run_ff <= 1'b0;
					done_ff <= 1'b1;
				end
				cnt_ff <= cnt_ff - ONE;
			end
		end
	end

endmodule // prog_timer

//--- tb/flash_self_write_asserts.sv
module flash_self_write_asserts #(
	parameter LONG_CYCLES = 50000,
	parameter CNT_W = 17
) (
	// clock and reset
	input logic core_clk,
	input logic rst_n,
	// bus
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_we_i,
	input logic [7:0] wb_adr_i,
	input logic [3:0] wb_sel_i,
	input logic [31:0] wb_dat_i,
	input logic [31:0] wb_dat_o,
	input logic wb_ack_o,
	// flash side
	input logic [20:0] flash_addr,
	input logic [15:0] flash_rdata,
	input logic flash_erase,
	input logic flash_prog,
	input logic [21:0] flash_op_addr,
	input logic [63:0] flash_wdata,
	input logic core_stall
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIM = LONG_CYCLES + 8;
	logic [31:0] stall_len;
	// cycles the core has been held in the current long cycle
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			stall_len <= 32'h00000000;
		else if (core_stall)
			stall_len <= stall_len + 32'h00000001;
		else
			stall_len <= 32'h00000000;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// bus answers and long cycle shape
	AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	AST_LONG_STALL: assert property ((flash_erase || flash_prog) |-> core_stall) else $error("no stall");
	AST_ONE_KIND: assert property (!(flash_erase && flash_prog)) else $error("erase with program");
	AST_ROW_ALIGN: assert property (flash_erase |-> flash_op_addr[5:0] == 6'h00) else $error("row");
	AST_BLK_ALIGN: assert property (flash_prog |-> flash_op_addr[2:0] == 3'h0) else $error("block");
	AST_HOLD_KEEP: assert property (flash_prog && $past(flash_prog) |-> $stable(flash_wdata)) else $error("hold");
	AST_STALL_MIN: assert property ($rose(core_stall) |=> core_stall [*8]) else $error("short cycle");
	AST_STALL_END: assert property (stall_len <= LIM) else $error("no end");
	AST_NO_ACK: assert property (core_stall && $past(core_stall) |-> !wb_ack_o) else $error("ack in cycle");
	AST_STALL_LEN: assert property ($fell(core_stall) |-> stall_len >= LONG_CYCLES) else $error("cycle cut");
	AST_RD_ACK: assert property ($changed(flash_addr) |=> wb_ack_o) else $error("read late");
	// main scenarios
	cover property ($rose(flash_erase));
	cover property ($rose(flash_prog));
	cover property ($fell(core_stall));
endmodule // flash_self_write_asserts

bind program_flash_self_write flash_self_write_asserts #(.LONG_CYCLES(LONG_CYCLES), .CNT_W(CNT_W)) u_chk (
	.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_erase(flash_erase), .flash_prog(flash_prog),
	.flash_op_addr(flash_op_addr), .flash_wdata(flash_wdata), .core_stall(core_stall));

//--- tb/flash_array_model.sv
module flash_array_model (
	// clock
	input logic core_clk,
	// array read port
	input logic [20:0] flash_addr,
	output logic [15:0] flash_rdata,
	// long operations
	input logic flash_erase,
	input logic flash_prog,
	input logic [21:0] flash_op_addr,
	input logic [63:0] flash_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic erase_d = 1'b0;
	logic prog_d = 1'b0;
	// high byte differs from low byte of each word
	initial
		for (int a = 0; a < 256; a++)
			mem[a] = {a[7:0] ^ 8'h5A, a[7:0]};
	assign flash_rdata = mem[flash_addr[7:0]];
	// erase blanks a 32-word row, program stores a 4-word block
	always @(posedge core_clk)
	begin
		erase_d <= flash_erase;
		prog_d <= flash_prog;
		if (flash_erase && !erase_d)
			for (int w = 0; w < 32; w++)
				mem[{flash_op_addr[8:6], w[4:0]}] <= 16'hFFFF;
		if (flash_prog && !prog_d)
			for (int w = 0; w < 4; w++)
				mem[{flash_op_addr[8:3], w[1:0]}] <= flash_wdata[w*16 +: 16];
	end
endmodule // flash_array_model

//--- tb/tb_program_flash_self_write.sv
`include "flash_self_write_defs.vh"

module tb_program_flash_self_write;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, flash_erase, flash_prog, core_stall;
	wire [20:0] flash_addr;
	wire [15:0] flash_rdata;
	wire [21:0] flash_op_addr;
	wire [63:0] flash_wdata;
	int n_mismatch = 0;
	int checks = 0;
	// 25 MHz clock
	always #20 core_clk = ~core_clk;
	program_flash_self_write #(.LONG_CYCLES(20), .CNT_W(17)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .flash_addr(flash_addr),
		.flash_rdata(flash_rdata), .flash_erase(flash_erase), .flash_prog(flash_prog),
		.flash_op_addr(flash_op_addr), .flash_wdata(flash_wdata), .core_stall(core_stall));
	flash_array_model u_flash (.core_clk(core_clk), .flash_addr(flash_addr), .flash_rdata(flash_rdata),
		.flash_erase(flash_erase), .flash_prog(flash_prog), .flash_op_addr(flash_op_addr),
		.flash_wdata(flash_wdata));
	task automatic conclude;
		$display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one classic cycle, held until ack
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int i;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
		for (i = 0; i < 200; i++)
		begin
			@(posedge core_clk);
			if (wb_ack_o === 1'b1)
				break;
		end
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge core_clk);
		if (i == 200)
		begin
			n_mismatch++;
			conclude();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		wb(1'b1, a, d, x);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		wb(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask
	function automatic logic [31:0] op(input logic r, input logic [1:0] m);
		return {28'h0, m, ~r, r};
	endfunction
	task automatic unlock;
		wr(`FSW_ADR_UNLOCK, 32'h55);
		wr(`FSW_ADR_UNLOCK, 32'hAA);
	endtask
	// wait for the long cycle to end
	task automatic wt_idle;
		int i;
		for (i = 0; i < 100 && core_stall !== 1'b0; i++)
			@(posedge core_clk);
		chk(core_stall, 1'b0);
		if (core_stall !== 1'b0)
			conclude();
	endtask
	task automatic t_read;
		wr(`FSW_ADR_PTR, 32'h105);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_POSTINC));
		rdc(`FSW_ADR_LATCH, 32'hD8);
		chk(flash_addr, 21'h82);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_POSTINC));
		rdc(`FSW_ADR_LATCH, 32'h83);
		rdc(`FSW_ADR_PTR, 32'h107);
		wr(`FSW_ADR_PTR, 32'h3FFFFF);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_POSTINC));
		rdc(`FSW_ADR_PTR, 32'h200000);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_POSTDEC));
		rdc(`FSW_ADR_PTR, 32'h3FFFFF);
		wr(`FSW_ADR_PTR, 32'h10);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_PREINC));
		rdc(`FSW_ADR_LATCH, 32'h52);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_KEEP));
		rdc(`FSW_ADR_PTR, 32'h11);
		$display("test read done");
	endtask
	task automatic t_prog;
		wr(`FSW_ADR_PTR, 32'h3F);
		for (int k = 0; k < 8; k++)
		begin
			wr(`FSW_ADR_LATCH, 32'hC0 + k);
			wr(`FSW_ADR_OP, op(1'b0, `FSW_MODE_PREINC));
		end
		rdc(`FSW_ADR_PTR, 32'h47);
		for (int r = 0; r < 2; r++)
		begin
			wr(`FSW_ADR_CTL, 32'h84);
			unlock();
			wr(`FSW_ADR_CTL, 32'h86);
			chk(flash_prog, 1'b1);
			chk(flash_op_addr, 22'h40);
			chk(flash_wdata, 64'hC7C6C5C4C3C2C1C0);
			wt_idle();
			rdc(`FSW_ADR_CTL, 32'h84);
			rdc(`FSW_ADR_STS, 32'h1);
			wr(`FSW_ADR_STS, 32'h1);
		end
		rdc(`FSW_ADR_STS, 32'h0);
		$display("test program done");
	endtask
	task automatic t_erase;
		wr(`FSW_ADR_PTR, 32'h1A5);
		wr(`FSW_ADR_CTL, 32'h94);
		unlock();
		wr(`FSW_ADR_CTL, 32'h96);
		chk({flash_erase, flash_prog}, 2'b10);
		chk(flash_op_addr, 22'h180);
		wt_idle();
		rdc(`FSW_ADR_CTL, 32'h84);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_KEEP));
		rdc(`FSW_ADR_LATCH, 32'hFF);
		wr(`FSW_ADR_PTR, 32'h1C0);
		wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_KEEP));
		rdc(`FSW_ADR_LATCH, 32'hE0);
		$display("test erase done");
	endtask
	// program the erased row as eight blocks, then read it back
	task automatic t_row;
		for (int g = 0; g < 8; g++)
		begin
			wr(`FSW_ADR_PTR, 32'h17F + 8 * g);
			for (int k = 0; k < 8; k++)
			begin
				wr(`FSW_ADR_LATCH, 8 * g + k + 32'h20);
				wr(`FSW_ADR_OP, op(1'b0, `FSW_MODE_PREINC));
			end
			wr(`FSW_ADR_CTL, 32'h84);
			unlock();
			wr(`FSW_ADR_CTL, 32'h86);
			wt_idle();
		end
		wr(`FSW_ADR_PTR, 32'h180);
		for (int b = 0; b < 64; b++)
		begin
			wr(`FSW_ADR_OP, op(1'b1, `FSW_MODE_POSTINC));
			rdc(`FSW_ADR_LATCH, b + 32'h20);
		end
		$display("test row update done");
	endtask
	task automatic t_refuse;
		wr(`FSW_ADR_UNLOCK, 32'h55);
		wr(8'h40, 32'hFF);
		rdc(8'h40, 32'h0);
		wr(`FSW_ADR_UNLOCK, 32'hAA);
		wr(`FSW_ADR_CTL, 32'h86);
		chk(core_stall, 1'b0);
		unlock();
		wr(`FSW_ADR_CTL, 32'h82);
		chk(core_stall, 1'b0);
		unlock();
		wr(`FSW_ADR_CTL, 32'hC6);
		chk(core_stall, 1'b0);
		$display("test refuse done");
	endtask
	initial
	begin
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		t_read();
		t_prog();
		t_erase();
		t_row();
		t_refuse();
		conclude();
	end
endmodule // tb_program_flash_self_write
